// ---- common/mmt_params.svh ----
// Constants for the multi-mode timer: register offsets, field positions, reset values.
// Assumes inclusion by bare name from the design files.
`ifndef MMT_PARAMS_SVH
`define MMT_PARAMS_SVH
// =============================================================
// Register byte offsets
`define MMT_CTRL_OFS 8'h00
`define MMT_PSC_OFS 8'h04
`define MMT_ARR_OFS 8'h08
`define MMT_CNT_OFS 8'h0C
`define MMT_STAT_OFS 8'h10
`define MMT_MASK_OFS 8'h14
`define MMT_DTIME_OFS 8'h18
`define MMT_CHCFG_OFS 8'h1C
`define MMT_CCR0_OFS 8'h20
// =============================================================
// Control fields
`define MMT_CTRL_EN 0
`define MMT_CTRL_DIR 1
`define MMT_CTRL_CMS 2
`define MMT_CTRL_OPM 3
`define MMT_CTRL_DBGF 4
`define MMT_CTRL_ENC 5
`define MMT_CTRL_HALL 6
`define MMT_CTRL_SLV 7
`define MMT_CTRL_DMAE 8
// =============================================================
// Status bits: 0 update, 1..4 channel events, 5 trigger in
`define MMT_ST_UPD 0
`define MMT_ST_TRG 5
`define MMT_ST_W 6
// =============================================================
// Reset values
`define MMT_CTRL_RST 32'h0000_0000
`define MMT_PSC_RST 16'h0000
`define MMT_ARR_RST 32'hFFFF_FFFF
`define MMT_DT_RST 8'h00
`endif

// ---- common/mmt_pkg.sv ----
// Types for the multi-mode timer.
// Assumes mmt_params.svh is on the include path.
`default_nettype none
package mmt_pkg;
  // =============================================================
  // Channel modes
  typedef enum logic [2:0] {
    MMT_CH_OFF = 3'h0,
    MMT_CH_CAP = 3'h1,
    MMT_CH_CMP = 3'h3,
    MMT_CH_PWM = 3'h2,
    MMT_CH_OPM = 3'h6
  } mmt_chmode_t;
  // Counter direction state, Gray along up -> down
  typedef enum logic [1:0] {
    MMT_DIR_UP = 2'b00,
    MMT_DIR_DN = 2'b01
  } mmt_dir_t;
  // Inter-timer trigger carrier
  typedef struct packed {
    logic start;
    logic update;
    logic reset;
  } mmt_trig_t;
  // Pin-facing outputs of one channel
  typedef struct packed {
    logic oc;
    logic ocn;
  } mmt_pair_t;
endpackage
`default_nettype wire

// ---- verilog/mmt_channel.sv ----
// One capture/compare channel with complementary dead-time output.
// Assumes counter and edge inputs are synchronous to sys_clk.
`default_nettype none
`include "mmt_params.svh"
module mmt_channel
  import mmt_pkg::*;
#(
  parameter int CW = 32,
  parameter int DTW = 8
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [2:0] mode,
  input wire logic [CW-1:0] ccr,
  input wire logic [CW-1:0] cnt,
  input wire logic [CW-1:0] arr,
  input wire logic running,
  input wire logic [DTW-1:0] dtime,
  input wire logic cap_in,
  output logic [CW-1:0] cap_val,
  output logic event_p,
  output mmt_pair_t pins
);
  logic cap_d1_q;
  logic ref_q;
  logic ref_d1_q;
  logic [DTW-1:0] dt_q;
  logic active;
  // =============================================================
  // Reference level: compare and PWM over full 0..100%
  always_comb
  begin
    case (mmt_chmode_t'(mode))
      MMT_CH_PWM: active = running && (cnt < ccr); // RL8
      MMT_CH_OPM: active = running && (cnt >= ccr) && (ccr <= arr); // RL5
      MMT_CH_CMP: active = ref_q ^ (running && cnt == ccr); // RL5
      default: active = 1'b0;
    endcase
  end
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      ref_q <= 1'b0;
      ref_d1_q <= 1'b0;
      cap_d1_q <= 1'b0;
      cap_val <= '0;
      event_p <= 1'b0;
    end
    else
    begin
      ref_q <= active;
      ref_d1_q <= ref_q;
      cap_d1_q <= cap_in;
      event_p <= 1'b0;
      if (mode == MMT_CH_CAP && cap_in && !cap_d1_q)
      begin
        cap_val <= cnt; // RL5
        event_p <= 1'b1;
      end
      else if (mode != MMT_CH_CAP && mode != MMT_CH_OFF && running && cnt == ccr)
        event_p <= 1'b1;
    end
  end
  // =============================================================
  // Dead time: delay each rising edge of either output
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      dt_q <= '0;
    else if (ref_q != ref_d1_q)
      dt_q <= dtime; // RL6
    else if (dt_q != '0)
      dt_q <= dt_q - 1'b1;
  end
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      pins <= '0;
    else
    begin
      pins.oc <= ref_q && (dt_q == '0) && (ref_q == ref_d1_q); // RL6
      pins.ocn <= !ref_q && (mode != MMT_CH_OFF) && (dt_q == '0) && (ref_q == ref_d1_q); // RL6
    end
  end
endmodule // mmt_channel
`default_nettype wire

// ---- verilog/mmt_timer.sv ----
// Multi-mode timer top: prescaler, auto-reload counter, four channels, AXI4-Lite slave.
// Assumes all pin inputs synchronous to sys_clk; single clock domain.
// Operation
// RL1 - The counter holds while the debug halt input is high and the freeze bit is set.
// RL2 - A prescaler divides the clock by any factor from 1 to 65536.
// RL3 - Counting may be up, down or alternating up/down by configuration.
// RL4 - The counter reloads from a programmable value; width is 32 or 16 bits.
// RL5 - Each of four channels does capture, compare, PWM or one-pulse output; here the one-pulse mode repeats every period, as nothing stops the counter.
// RL6 - Each channel drives a complementary pair with programmable dead time.
// RL7 - The complementary pairs of three channels form six phase outputs.
// RL8 - PWM duty spans constantly inactive through constantly active.
// RL9 - Trigger inputs from other timers start or reset this one; triggers go out.
// RL10 - Quadrature encoder and hall sensor inputs drive direction and counts; here a hall change only fires a capture on channel 0.
// RL11 - Timer events raise this instance's own DMA request.
// RL12 - With no channels the timer is a time base whose update paces a DAC.
// RL13 - Overflow or underflow reloads the counter and sets the update flag.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`default_nettype none
`include "mmt_params.svh"
module mmt_timer
  import mmt_pkg::*;
#(
  parameter int CW = 32,
  parameter int NCH = 4,
  parameter int DTW = 8
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic dbg_halt,
  input wire mmt_trig_t trig_in,
  output mmt_trig_t trig_out,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic [2:0] hall_in,
  input wire logic [NCH-1:0] cap_in,
  output mmt_pair_t [NCH-1:0] ch_out,
  output logic [5:0] phase_out,
  output logic dma_req,
  output logic dac_trig,
  output logic irq
);
  logic [31:0] ctrl_q;
  logic [15:0] psc_q;
  logic [15:0] pcnt_q;
  logic [CW-1:0] arr_q;
  logic [CW-1:0] cnt_q;
  logic [`MMT_ST_W-1:0] stat_q;
  logic [`MMT_ST_W-1:0] mask_q;
  logic [DTW-1:0] dt_q;
  logic [3*NCH-1:0] chcfg_q;
  logic [CW-1:0] ccr_q [NCH];
  logic [CW-1:0] cap_val [NCH];
  logic [NCH-1:0] ch_ev;
  mmt_dir_t dir_q;
  logic tick;
  logic halted;
  logic upd;
  logic enc_step;
  logic enc_up;
  mmt_dir_t cdir;
  logic [1:0] enc_q;
  logic [2:0] hall_q;
  logic hall_ev;
  logic aw_hold_q;
  logic w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_go;
  logic [31:0] rd_val;
  logic [`MMT_ST_W-1:0] ev_set;
  logic [`MMT_ST_W-1:0] w1c;
  // =============================================================
  // Prescaler and halt
  assign halted = ctrl_q[`MMT_CTRL_DBGF] && dbg_halt; // RL1
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      pcnt_q <= 16'h0000;
    else if (!ctrl_q[`MMT_CTRL_EN] || halted)
      pcnt_q <= pcnt_q; // RL1
    else if (pcnt_q >= psc_q)
      pcnt_q <= 16'h0000; // RL2
    else
      pcnt_q <= pcnt_q + 16'h0001;
  end
  // Encoder and hall inputs
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      enc_q <= 2'b00;
      hall_q <= 3'b000;
    end
    else
    begin
      enc_q <= {enc_a, enc_b};
      hall_q <= hall_in;
    end
  end
  assign enc_step = (enc_q[1] ^ enc_a) ^ (enc_q[0] ^ enc_b); // RL10
  assign enc_up = enc_q[1] ^ enc_b; // RL10
  assign hall_ev = ctrl_q[`MMT_CTRL_HALL] && (hall_q != hall_in); // RL10
  always_comb
  begin
    if (!ctrl_q[`MMT_CTRL_EN] || halted)
      tick = 1'b0;
    else if (ctrl_q[`MMT_CTRL_SLV])
      tick = trig_in.start; // RL9
    else if (ctrl_q[`MMT_CTRL_ENC])
      tick = enc_step; // RL10
    else
      tick = (pcnt_q >= psc_q); // RL2
  end
  // =============================================================
  // Counter with reload
  assign cdir = (ctrl_q[`MMT_CTRL_ENC] && enc_step) ? (enc_up ? MMT_DIR_UP : MMT_DIR_DN) : dir_q;
  assign upd = tick && ((cdir == MMT_DIR_UP) ? (cnt_q >= arr_q) : (cnt_q == '0)); // RL13
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      cnt_q <= '0;
      dir_q <= MMT_DIR_UP;
    end
    else if (trig_in.reset)
      cnt_q <= '0; // RL9
    else
    begin
      if (ctrl_q[`MMT_CTRL_ENC])
        dir_q <= cdir; // RL10
      else if (!ctrl_q[`MMT_CTRL_CMS])
        dir_q <= ctrl_q[`MMT_CTRL_DIR] ? MMT_DIR_DN : MMT_DIR_UP; // RL3
      if (tick)
      begin
        if (ctrl_q[`MMT_CTRL_CMS])
        begin
          if (dir_q == MMT_DIR_UP && cnt_q >= arr_q)
          begin
            dir_q <= MMT_DIR_DN; // RL3
            cnt_q <= arr_q - 1'b1;
          end
          else if (dir_q == MMT_DIR_DN && cnt_q == '0)
          begin
            dir_q <= MMT_DIR_UP; // RL3
            cnt_q <= CW'(1);
          end
          else
            cnt_q <= (dir_q == MMT_DIR_UP) ? cnt_q + 1'b1 : cnt_q - 1'b1;
        end
        else if (upd)
          cnt_q <= (cdir == MMT_DIR_UP) ? '0 : arr_q; // RL4 RL13
        else
          cnt_q <= (cdir == MMT_DIR_UP) ? cnt_q + 1'b1 : cnt_q - 1'b1;
      end
    end
  end
  // =============================================================
  // Channels
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_ch
      mmt_channel #(.CW(CW), .DTW(DTW)) u_ch (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .mode(chcfg_q[3*gi +: 3]),
        .ccr(ccr_q[gi]),
        .cnt(cnt_q),
        .arr(arr_q),
        .running(ctrl_q[`MMT_CTRL_EN]),
        .dtime(dt_q),
        .cap_in(cap_in[gi] ^ (gi == 0 && hall_ev)),
        .cap_val(cap_val[gi]),
        .event_p(ch_ev[gi]),
        .pins(ch_out[gi])
      ); // RL5
    end
  endgenerate
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      phase_out[2*i] = (i < NCH) ? ch_out[i].oc : 1'b0; // RL7
      phase_out[2*i+1] = (i < NCH) ? ch_out[i].ocn : 1'b0; // RL7
    end
  end
  // =============================================================
  // Events, interrupt, DMA, trigger out
  assign ev_set = {trig_in.start, ch_ev, upd};
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      stat_q <= '0;
    else
      stat_q <= (stat_q & ~w1c) | ev_set; // RL13
  end
  assign irq = |(stat_q & mask_q);
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      dma_req <= 1'b0;
      dac_trig <= 1'b0;
      trig_out <= '0;
    end
    else
    begin
      dma_req <= ctrl_q[`MMT_CTRL_DMAE] && (upd || |ch_ev); // RL11
      dac_trig <= upd; // RL12
      trig_out.update <= upd; // RL9
      trig_out.start <= ctrl_q[`MMT_CTRL_EN] && !halted; // RL9
      trig_out.reset <= upd; // RL9
    end
  end
  // =============================================================
  // AXI4-Lite write
  assign s_axi_awready = !aw_hold_q;
  assign s_axi_wready = !w_hold_q;
  assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  assign s_axi_bresp = 2'b00;
  assign w1c = (wr_go && awaddr_q == `MMT_STAT_OFS && wstrb_q[0]) ?
               wdata_q[`MMT_ST_W-1:0] : '0;
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      ctrl_q <= `MMT_CTRL_RST;
      psc_q <= `MMT_PSC_RST;
      arr_q <= CW'(`MMT_ARR_RST);
      mask_q <= '0;
      dt_q <= `MMT_DT_RST;
      chcfg_q <= '0;
      for (int i = 0; i < NCH; i++)
        ccr_q[i] <= '0;
    end
    else if (wr_go && wstrb_q == 4'hF)
    begin
      case (awaddr_q)
        `MMT_CTRL_OFS: ctrl_q <= wdata_q;
        `MMT_PSC_OFS: psc_q <= wdata_q[15:0]; // RL2
        `MMT_ARR_OFS: arr_q <= wdata_q[CW-1:0]; // RL4
        `MMT_MASK_OFS: mask_q <= wdata_q[`MMT_ST_W-1:0];
        `MMT_DTIME_OFS: dt_q <= wdata_q[DTW-1:0]; // RL6
        `MMT_CHCFG_OFS: chcfg_q <= wdata_q[3*NCH-1:0];
        default:
        begin
          for (int i = 0; i < NCH; i++)
            if (awaddr_q == `MMT_CCR0_OFS + 8'(4*i))
              ccr_q[i] <= wdata_q[CW-1:0];
        end
      endcase
    end
  end
  // =============================================================
  // AXI4-Lite read
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = 2'b00;
  always_comb
  begin
    rd_val = 32'h0000_0000;
    case (s_axi_araddr)
      `MMT_CTRL_OFS: rd_val = ctrl_q;
      `MMT_PSC_OFS: rd_val = {16'h0000, psc_q};
      `MMT_ARR_OFS: rd_val = 32'(arr_q);
      `MMT_CNT_OFS: rd_val = 32'(cnt_q);
      `MMT_STAT_OFS: rd_val = 32'(stat_q);
      `MMT_MASK_OFS: rd_val = 32'(mask_q);
      `MMT_DTIME_OFS: rd_val = 32'(dt_q);
      `MMT_CHCFG_OFS: rd_val = 32'(chcfg_q);
      default:
      begin
        for (int i = 0; i < NCH; i++)
          if (s_axi_araddr == `MMT_CCR0_OFS + 8'(4*i))
            rd_val = 32'((chcfg_q[3*i +: 3] == MMT_CH_CAP) ? cap_val[i] : ccr_q[i]);
      end
    endcase
  end
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule // mmt_timer
`default_nettype wire

// ---- dv/mmt_pins_model.sv ----
// Pin-side model: capture sources, a stepped quadrature encoder and quiet hall lines.
// Assumes the bench pulses cap_go for one cycle with cap_sel valid.
`default_nettype none
module mmt_pins_model
(
  input wire logic sys_clk,
  input wire logic cap_go,
  input wire logic [1:0] cap_sel,
  input wire logic enc_go,
  input wire logic enc_rev,
  output logic [3:0] cap_in,
  output logic enc_a,
  output logic enc_b,
  output logic [2:0] hall_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // =============================================================
  // Capture edge held two cycles
  logic [1:0] hold_q;
  initial
  begin
    cap_in = 4'h0;
    hold_q = 2'h0;
  end
  always @(posedge sys_clk)
  begin
    hold_q <= cap_go ? 2'h2 : (hold_q != 2'h0 ? hold_q - 2'h1 : 2'h0);
    cap_in <= (cap_go || hold_q > 2'h1) ? (4'h1 << cap_sel) : 4'h0;
  end
  // Encoder phase advances one Gray step per enc_go
  logic [1:0] ph_q = 2'h0;
  always @(posedge sys_clk)
  begin
    if (enc_go)
      ph_q <= enc_rev ? ph_q - 2'h1 : ph_q + 2'h1;
  end
  assign enc_a = ph_q[1];
  assign enc_b = ph_q[1] ^ ph_q[0];
  assign hall_in = 3'h0;
endmodule // mmt_pins_model
`default_nettype wire

// ---- dv/mmt_timer_sva.sv ----
// Checker for the multi-mode timer top ports.
// Assumes a single sys_clk domain with synchronous active-low rstn.
`default_nettype none
module mmt_timer_chk
  import mmt_pkg::*;
#(
  parameter int NCH = 4
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire mmt_trig_t trig_out,
  input wire mmt_pair_t [NCH-1:0] ch_out,
  input wire logic [5:0] phase_out,
  input wire logic dac_trig
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // =============================================================
  // Bus handshakes
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read answer dropped");
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_wr_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped");
  // =============================================================
  // Events and outputs
  property p_upd_pulse;
    trig_out.update |=> !trig_out.update || trig_out.reset;
  endproperty
  a_upd_pulse: assert property (p_upd_pulse) else $error("update not paired");
  property p_dac;
    dac_trig == trig_out.update;
  endproperty
  a_dac: assert property (p_dac) else $error("dac pulse differs");
  property p_phase;
    phase_out == {ch_out[2].ocn, ch_out[2].oc, ch_out[1].ocn, ch_out[1].oc,
      ch_out[0].ocn, ch_out[0].oc};
  endproperty
  a_phase: assert property (p_phase) else $error("phase lines differ");
  property p_dead;
    !(ch_out[0].oc && ch_out[0].ocn) && !(ch_out[1].oc && ch_out[1].ocn);
  endproperty
  a_dead: assert property (p_dead) else $error("pair overlap");
  c_upd: cover property (trig_out.update);
  c_oc: cover property (ch_out[0].oc);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule // mmt_timer_chk
bind mmt_timer mmt_timer_chk #(.NCH(NCH)) chk_u (.sys_clk(sys_clk), .rstn(rstn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .trig_out(trig_out), .ch_out(ch_out),
  .phase_out(phase_out), .dac_trig(dac_trig));
`default_nettype wire

// ---- dv/test_multi_mode_timer.sv ----
// Self-checking bench for the multi-mode timer.
// Assumes the pin model drives capture inputs; AXI4-Lite master in bench tasks.
`default_nettype none
module test_multi_mode_timer;
  import mmt_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 0, rstn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, dbg = 0, go = 0;
  logic ego = 0, erev = 0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0000_0000, rd, v;
  logic [1:0] sel = 2'h0;
  logic awr, wr, bv, arr_r, rv, dac, irq, dma, seen, all1;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] cap;
  logic ea, eb;
  logic [2:0] hall;
  logic [5:0] ph;
  mmt_trig_t tin = '0, tout;
  mmt_pair_t [3:0] cho;
  int mismatches = 0, checks = 0, cyc = 0, n, p, a;
  always #2.5 sys_clk = ~sys_clk;
  mmt_pins_model pin_u (.sys_clk(sys_clk), .cap_go(go), .cap_sel(sel), .cap_in(cap),
    .enc_go(ego), .enc_rev(erev),
    .enc_a(ea), .enc_b(eb), .hall_in(hall));
  mmt_timer dut_u (.sys_clk(sys_clk), .rstn(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr_r), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .dbg_halt(dbg),
    .trig_in(tin), .trig_out(tout), .enc_a(ea), .enc_b(eb), .hall_in(hall), .cap_in(cap),
    .ch_out(cho), .phase_out(ph), .dma_req(dma), .dac_trig(dac), .irq(irq));
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc > 40000)
    begin
      mismatches++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
    checks++;
    if (seen_v !== exp_v)
    begin
      mismatches++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
    end
  endtask
  task automatic axw(input logic [7:0] ad, input logic [31:0] d);
    awa <= ad;
    wd <= d;
    awv <= 1;
    wv <= 1;
    br <= 1;
    do
    begin
      @(posedge sys_clk);
      if (awr) awv <= 0;
      if (wr) wv <= 0;
    end while (!bv);
    br <= 0;
  endtask
  task automatic axr(input logic [7:0] ad, output logic [31:0] d);
    ara <= ad;
    arv <= 1;
    rr <= 1;
    do
    begin
      @(posedge sys_clk);
      if (arr_r) arv <= 0;
    end while (!rv);
    d = rdata;
    rr <= 0;
  endtask
  task automatic per(output int c);
    c = 0;
    do @(posedge sys_clk); while (!tout.update);
    do
    begin
      @(posedge sys_clk);
      c++;
    end while (!tout.update);
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  function automatic int exp_per(input int ps, input int ar);
    return (ps + 1) * (ar + 1);
  endfunction
  initial
  begin
    void'($urandom(32'h380f));
    wt(5);
    rstn <= 1;
    wt(1);
    axr(`MMT_CTRL_OFS, rd); chk(rd, `MMT_CTRL_RST);
    axr(`MMT_ARR_OFS, rd); chk(rd, `MMT_ARR_RST);
    axr(8'hFC, rd); chk(rd, 32'h0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      p = (i == 0) ? 0 : $urandom % 4;
      a = (i == 0) ? 1 : 3 + $urandom % 6;
      axw(`MMT_PSC_OFS, p);
      axw(`MMT_ARR_OFS, a);
      axw(`MMT_CTRL_OFS, 32'h0000_0001 | ((i % 2) << `MMT_CTRL_DIR));
      per(n);
      chk(n, exp_per(p, a));
    end
    axw(`MMT_CTRL_OFS, 32'h0000_0000);
    axr(`MMT_STAT_OFS, rd); chk(rd[0], 1'b1);
    axw(`MMT_MASK_OFS, 32'h0000_0001);
    wt(1); chk(irq, 1'b1);
    axw(`MMT_STAT_OFS, 32'h0000_003F);
    wt(1); chk(irq, 1'b0);
    axw(`MMT_ARR_OFS, 32'h0000_1000);
    axw(`MMT_CTRL_OFS, 32'h0000_0011);
    dbg <= 1;
    wt(2);
    axr(`MMT_CNT_OFS, v);
    wt(10);
    axr(`MMT_CNT_OFS, rd); chk(rd, v);
    dbg <= 0;
    tin.reset <= 1;
    wt(3);
    axr(`MMT_CNT_OFS, rd); chk(rd, 32'h0000_0000);
    tin <= '{start: 1'b1, update: 1'b0, reset: 1'b0};
    wt(1);
    tin <= '0;
    axr(`MMT_STAT_OFS, rd); chk(rd[`MMT_ST_TRG], 1'b1);
    axw(`MMT_ARR_OFS, 32'h0000_0007);
    axw(`MMT_PSC_OFS, 32'h0000_0000);
    axw(`MMT_CHCFG_OFS, 32'(MMT_CH_PWM));
    v = 32'h0000_0000;
    for (int k = 0; k < 2; k++)
    begin
      axw(`MMT_CCR0_OFS, k * 8);
      axw(`MMT_CTRL_OFS, 32'h0000_0101);
      wt(20);
      seen = 0;
      all1 = 1;
      for (int j = 0; j < 16; j++)
      begin
        @(posedge sys_clk);
        seen |= cho[0].oc;
        all1 &= cho[0].oc;
        if (dma) v[0] = 1'b1;
      end
      chk(k ? all1 : seen, k ? 1'b1 : 1'b0);
    end
    chk(v[0], 1'b1);
    axw(`MMT_CHCFG_OFS, 32'(MMT_CH_CAP) << 3);
    axw(`MMT_STAT_OFS, 32'h0000_003F);
    sel <= 2'h1;
    go <= 1;
    wt(1);
    go <= 0;
    wt(6);
    axr(`MMT_STAT_OFS, rd); chk(rd[2], 1'b1);
    axw(`MMT_CTRL_OFS, 32'h0000_0081);
    wt(1);
    chk(tout.start, 1'b1);
    tin.reset <= 1;
    wt(1);
    tin.reset <= 0;
    repeat (3)
    begin
      tin.start <= 1;
      wt(1);
      tin.start <= 0;
      wt(1);
    end
    axr(`MMT_CNT_OFS, rd); chk(rd, 32'h0000_0003);
    axw(`MMT_CTRL_OFS, 32'h0000_0021);
    tin.reset <= 1;
    wt(1);
    tin.reset <= 0;
    for (int j = 0; j < 8; j++)
    begin
      erev <= (j >= 6);
      ego <= 1;
      wt(1);
      ego <= 0;
      wt(2);
    end
    axr(`MMT_CNT_OFS, rd); chk(rd, 32'h0000_0004);
    test_done();
  end
endmodule // test_multi_mode_timer
`default_nettype wire
